/* File: hdl/rtc_pkg.sv */
// Summary of operation
// - divider mode bits are always host accessible and survive host reset.
// - mode 00x stops oscillator, 01x and 10x run, 11x holds divider.
// - first update comes half a second after divider hold is released.
// - rate code picks one of thirteen taps, zero disables; survives host reset.
// - rate code sets periodic period from 122.070 us up to 500 ms.
// - update-hold low advances time each second; high aborts and blocks updates.
// - update-hold changes only by host writes.
// - periodic enable gates only the output; periodic flag still sets; reset clears enable.
// - alarm when time bytes match alarm bytes, 11xxxxxx matches any; reset clears enable.
// - update-done enable cleared by host reset and by update-hold rising.
// - daylight-saving bit and reserved bit always read zero.
// - binary format select is one for binary; only host writes change it.
// - hours format is one for 24-hour; only host writes change it.
// - summary flag is any flag with its enable; interrupt pin low while set.
// - host reset clears all flags; reading the flag register clears all but those set in the read cycle.
// - periodic flag sets on the selected tap edge regardless of enable.
// - alarm flag sets at the end of an update when current time matches alarm time.
// - update-done flag sets at the end of every update not aborted by update-hold or a stopped or held divider.
// - flag register low nibble reads zero and ignores writes.
// - valid-time bit is read only, cleared by low battery, set by reading it.
// - valid-time register bits six to zero read zero and ignore writes.
// - general purpose bytes stay accessible during updates and are retained.
// - update pending rises at least 244 us before an update and holds through it.
// - writing update-hold as one inhibits updates, then clears update pending.
// - flag reads are latched; later events wait; only flags read as one clear.
package rtc_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int OSC_HZ = 32_768;
  localparam int UIP_LEAD_US = 244;
  localparam int UIP_LEAD_CYC = UIP_LEAD_US * CLK_MHZ;
  localparam int UPD_CYCLE_US = 1948;
  localparam int UPD_CYCLE_CYC = UPD_CYCLE_US * CLK_MHZ;
  localparam int ACC_W = 26;
  localparam int CNT_W = 16;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_SEC = 8'h00;
  localparam logic [7:0] IDX_SEC_ALM = 8'h01;
  localparam logic [7:0] IDX_MIN = 8'h02;
  localparam logic [7:0] IDX_MIN_ALM = 8'h03;
  localparam logic [7:0] IDX_HR = 8'h04;
  localparam logic [7:0] IDX_HR_ALM = 8'h05;
  localparam logic [7:0] IDX_DIV_RATE = 8'h0A;
  localparam logic [7:0] IDX_CTRL = 8'h0B;
  localparam logic [7:0] IDX_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_VALID = 8'h0D;
  localparam logic [7:0] IDX_INIT_LAST = 8'h0D;
  // field positions
  localparam int UIP_BIT = 7;
  localparam int DV_LSB = 4;
  localparam int RS_LSB = 0;
  localparam int SET_BIT = 7;
  localparam int PIE_BIT = 6;
  localparam int AIE_BIT = 5;
  localparam int UIE_BIT = 4;
  localparam int DM_BIT = 2;
  localparam int HF_BIT = 1;
  localparam int IRQ_SUMMARY_FLAG_BIT = 7;
  localparam int VRT_BIT = 7;
  // reset values and codes
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] ALM_ANY = 2'b11;
  localparam logic [1:0] DV_STOP = 2'b00;
  localparam logic [1:0] DV_HOLD = 2'b11;
  localparam int DIV_W = 15;
  localparam logic [14:0] DIV_HALF = 15'h4000;
  typedef enum logic [1:0] {UPD_IDLE, UPD_PENDING, UPD_BUSY} upd_state_e;
endpackage

/* File: hdl/osc_tick_gen.sv */
`timescale 1ns/100ps
module osc_tick_gen #(
  parameter logic [25:0] STEP = 26'h0008000,
  parameter logic [25:0] MODULUS = 26'h17D7840
) (
  input wire logic clk_i,
  input wire logic init_i,
  output logic tick_o
);
  logic [rtc_pkg::ACC_W-1:0] acc_reg;
  logic [rtc_pkg::ACC_W-1:0] acc_next;

  // phase accumulator gives the time base enable
  assign acc_next = acc_reg + STEP;

  always_ff @(posedge clk_i) begin
    if (init_i) begin
      acc_reg <= '0;
      tick_o <= 1'b0;
    end else if (acc_next >= MODULUS) begin
      acc_reg <= acc_next - MODULUS;
      tick_o <= 1'b1;
    end else begin
      acc_reg <= acc_next;
      tick_o <= 1'b0;
    end
  end
endmodule // osc_tick_gen

/* File: hdl/divider_chain.sv */
`timescale 1ns/100ps
module divider_chain (
  input wire logic clk_i,
  input wire logic init_i,
  input wire logic tick_i,
  input wire logic [2:0] dv_i,
  input wire logic [3:0] rate_i,
  output logic periodic_o,
  output logic second_o
);
  logic [rtc_pkg::DIV_W-1:0] cnt_reg;
  logic [rtc_pkg::DIV_W-1:0] cnt_next;
  logic osc_on;
  logic hold;
  logic [3:0] tap;

  // tap index for a rate code
  function automatic logic [3:0] tap_of(input logic [3:0] r);
    case (r)
      4'h1: tap_of = 4'h6;
      4'h2: tap_of = 4'h7;
      default: tap_of = r - 4'h2;
    endcase
  endfunction

  assign osc_on = dv_i[2:1] != rtc_pkg::DV_STOP;
  assign hold = dv_i[2:1] == rtc_pkg::DV_HOLD;
  assign cnt_next = cnt_reg + 15'h0001;
  assign tap = tap_of(rate_i);

  // held at half count so release gives a half second to the first update
  always_ff @(posedge clk_i) begin
    if (init_i) begin
      cnt_reg <= '0;
    end else if (hold) begin
      cnt_reg <= rtc_pkg::DIV_HALF;
    end else if (osc_on && tick_i) begin
      cnt_reg <= cnt_next;
    end
  end

  // rising edge of the chosen tap and the one second wrap
  always_ff @(posedge clk_i) begin
    if (init_i) begin
      periodic_o <= 1'b0;
      second_o <= 1'b0;
    end else begin
      periodic_o <= osc_on && !hold && tick_i && rate_i != 4'h0 &&
                    cnt_next[tap] && !cnt_reg[tap];
      second_o <= osc_on && !hold && tick_i && (&cnt_reg);
    end
  end
endmodule // divider_chain

/* File: hdl/rtc_control_status_regs.sv */
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/100ps
module rtc_control_status_regs #(
  parameter int UIP_LEAD_CYC = rtc_pkg::UIP_LEAD_CYC,
  parameter int UPD_CYC = rtc_pkg::UPD_CYCLE_CYC,
  parameter int OSC_STEP = rtc_pkg::OSC_HZ,
  parameter int CLK_MODULUS = rtc_pkg::CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pwr_init_i,
  input wire logic battery_low_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_out_n_o,
  output logic time_advance_o,
  output logic binary_format_o,
  output logic hour24_o
);
  // ****************************************
  // declarations
  // ****************************************
  logic ack_reg;
  logic [7:0] rd_idx_reg;
  logic [7:0] byte_reg [0:255];
  logic [2:0] divider_mode_bits_reg;
  logic [3:0] periodic_rate_code_reg;
  logic set_reg;
  logic periodic_irq_enable_reg;
  logic alarm_irq_enable_reg;
  logic update_done_irq_enable_reg;
  logic binary_format_select_reg;
  logic hour24_reg;
  logic [2:0] flags_reg;
  logic time_valid_flag_reg;
  rtc_pkg::upd_state_e state_reg;
  logic [rtc_pkg::CNT_W-1:0] cnt_reg;
  logic [rtc_pkg::CNT_W-1:0] lead_cnt_reg;
  logic [7:0] dat_reg;
  logic wb_req;
  logic [7:0] idx;
  logic wr;
  logic rd;
  logic wr_ctrl;
  logic rd_flags;
  logic osc_tick;
  logic periodic_p;
  logic second_p;
  logic running;
  logic abort;
  logic upd_done;
  logic alarm_hit;
  logic update_pending;
  logic irq_summary_flag;
  logic [2:0] flag_evt;
  logic [2:0] flag_en;
  logic [7:0] rd_mux;
  localparam int CNT_W = rtc_pkg::CNT_W;

  // ****************************************
  // time base and divider chain
  // ****************************************
  osc_tick_gen #(
    .STEP(26'(OSC_STEP)),
    .MODULUS(26'(CLK_MODULUS))
  ) u_tick (
    .clk_i(clk_i),
    .init_i(pwr_init_i),
    .tick_o(osc_tick)
  );

  divider_chain u_div (
    .clk_i(clk_i),
    .init_i(pwr_init_i),
    .tick_i(osc_tick),
    .dv_i(divider_mode_bits_reg),
    .rate_i(periodic_rate_code_reg),
    .periodic_o(periodic_p),
    .second_o(second_p)
  );

  // ****************************************
  // bus decode
  // ****************************************
  assign wb_req = cyc_i && stb_i && !ack_reg;
  assign idx = adr_i[9:2];
  assign wr = wb_req && we_i && sel_i[0];
  assign rd = wb_req && !we_i;
  assign wr_ctrl = wr && idx == rtc_pkg::IDX_CTRL;
  assign rd_flags = rd && idx == rtc_pkg::IDX_FLAGS;
  assign ack_o = ack_reg;
  assign dat_o = {24'h000000, dat_reg};

  // alarm byte matches its time byte or holds the any code
  function automatic logic byte_match(input logic [7:0] t, input logic [7:0] a);
    byte_match = (a[7:6] == rtc_pkg::ALM_ANY) || (t == a);
  endfunction

  // read data selection
  always_comb begin
    case (idx)
      rtc_pkg::IDX_DIV_RATE: rd_mux = {update_pending, divider_mode_bits_reg,
                                       periodic_rate_code_reg};
      rtc_pkg::IDX_CTRL: rd_mux = {set_reg, periodic_irq_enable_reg,
                                   alarm_irq_enable_reg, update_done_irq_enable_reg,
                                   1'b0, binary_format_select_reg,
                                   hour24_reg, 1'b0};
      rtc_pkg::IDX_FLAGS: rd_mux = {irq_summary_flag, flags_reg, 4'h0};
      rtc_pkg::IDX_VALID: rd_mux = {time_valid_flag_reg, 7'h00};
      default: rd_mux = byte_reg[idx];
    endcase
  end

  // single wait state answer, read data captured with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_init_i) begin
      ack_reg <= 1'b0;
      dat_reg <= rtc_pkg::BYTE_RST;
      rd_idx_reg <= rtc_pkg::BYTE_RST;
    end else begin
      ack_reg <= wb_req;
      rd_idx_reg <= idx;
      if (rd) begin
        dat_reg <= rd_mux;
      end
    end
  end

  // ****************************************
  // byte storage
  // ****************************************
  // time, alarm and general purpose bytes; A to D live in their own flops
  always_ff @(posedge clk_i) begin
    if (pwr_init_i) begin
      for (int i = 0; i <= int'(rtc_pkg::IDX_INIT_LAST); i++) begin
        byte_reg[i] <= rtc_pkg::BYTE_RST;
      end
    end else if (wr && (idx < rtc_pkg::IDX_DIV_RATE || idx > rtc_pkg::IDX_VALID)) begin
      byte_reg[idx] <= dat_i[7:0];
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // divider mode and rate code, untouched by host reset
  always_ff @(posedge clk_i) begin
    if (pwr_init_i) begin
      divider_mode_bits_reg <= 3'h0;
      periodic_rate_code_reg <= 4'h0;
    end else if (wr && idx == rtc_pkg::IDX_DIV_RATE) begin
      divider_mode_bits_reg <= dat_i[rtc_pkg::DV_LSB +: 3];
      periodic_rate_code_reg <= dat_i[rtc_pkg::RS_LSB +: 4];
    end
  end

  // update hold and formats change only by host writes
  always_ff @(posedge clk_i) begin
    if (pwr_init_i) begin
      set_reg <= 1'b0;
      binary_format_select_reg <= 1'b0;
      hour24_reg <= 1'b0;
    end else if (wr_ctrl) begin
      set_reg <= dat_i[rtc_pkg::SET_BIT];
      binary_format_select_reg <= dat_i[rtc_pkg::DM_BIT];
      hour24_reg <= dat_i[rtc_pkg::HF_BIT];
    end
  end

  // enables cleared by host reset
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_init_i) begin
      periodic_irq_enable_reg <= 1'b0;
      alarm_irq_enable_reg <= 1'b0;
      update_done_irq_enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      periodic_irq_enable_reg <= dat_i[rtc_pkg::PIE_BIT];
      alarm_irq_enable_reg <= dat_i[rtc_pkg::AIE_BIT];
      if (dat_i[rtc_pkg::SET_BIT] && !set_reg) begin
        update_done_irq_enable_reg <= 1'b0;
      end else begin
        update_done_irq_enable_reg <= dat_i[rtc_pkg::UIE_BIT];
      end
    end
  end

  assign binary_format_o = binary_format_select_reg;
  assign hour24_o = hour24_reg;

  // ****************************************
  // update cycle sequencer
  // ****************************************
  assign running = divider_mode_bits_reg[2:1] != rtc_pkg::DV_STOP &&
                   divider_mode_bits_reg[2:1] != rtc_pkg::DV_HOLD;
  assign abort = set_reg || !running;
  assign update_pending = state_reg != rtc_pkg::UPD_IDLE;
  assign upd_done = state_reg == rtc_pkg::UPD_BUSY && cnt_reg == '0 && !abort;

  // lead time with pending high, then the update itself
  always_ff @(posedge clk_i) begin
    if (pwr_init_i) begin
      state_reg <= rtc_pkg::UPD_IDLE;
      cnt_reg <= '0;
      time_advance_o <= 1'b0;
    end else begin
      time_advance_o <= 1'b0;
      case (state_reg)
        rtc_pkg::UPD_IDLE: begin
          if (second_p && !abort) begin
            state_reg <= rtc_pkg::UPD_PENDING;
            cnt_reg <= CNT_W'(UIP_LEAD_CYC - 1);
          end
        end
        rtc_pkg::UPD_PENDING: begin
          if (abort) begin
            state_reg <= rtc_pkg::UPD_IDLE;
          end else if (cnt_reg == '0) begin
            state_reg <= rtc_pkg::UPD_BUSY;
            cnt_reg <= CNT_W'(UPD_CYC - 1);
            time_advance_o <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        rtc_pkg::UPD_BUSY: begin
          if (abort || cnt_reg == '0) begin
            state_reg <= rtc_pkg::UPD_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= rtc_pkg::UPD_IDLE;
      endcase
    end
  end

  // ****************************************
  // event flags and interrupt
  // ****************************************
  assign alarm_hit = byte_match(byte_reg[rtc_pkg::IDX_SEC], byte_reg[rtc_pkg::IDX_SEC_ALM]) &&
                     byte_match(byte_reg[rtc_pkg::IDX_MIN], byte_reg[rtc_pkg::IDX_MIN_ALM]) &&
                     byte_match(byte_reg[rtc_pkg::IDX_HR], byte_reg[rtc_pkg::IDX_HR_ALM]);
  // order is periodic, alarm, update done
  assign flag_evt = {periodic_p, upd_done && alarm_hit, upd_done};
  assign flag_en = {periodic_irq_enable_reg, alarm_irq_enable_reg,
                    update_done_irq_enable_reg};
  assign irq_summary_flag = |(flags_reg & flag_en);
  assign irq_out_n_o = !irq_summary_flag;

  // a flag read as one clears; an event in the read cycle sets afterward
  for (genvar g = 0; g < 3; g++) begin : g_flag
    always_ff @(posedge clk_i) begin
      if (rst_i || pwr_init_i) begin
        flags_reg[g] <= 1'b0;
      end else if (flag_evt[g]) begin
        flags_reg[g] <= 1'b1;
      end else if (rd_flags) begin
        flags_reg[g] <= 1'b0;
      end
    end
  end

  // valid time bit
  always_ff @(posedge clk_i) begin
    if (pwr_init_i || battery_low_i) begin
      time_valid_flag_reg <= 1'b0;
    end else if (rd && idx == rtc_pkg::IDX_VALID) begin
      time_valid_flag_reg <= 1'b1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // cycles spent with pending high before the update starts
  always_ff @(posedge clk_i) begin
    if (pwr_init_i || state_reg != rtc_pkg::UPD_PENDING) begin
      lead_cnt_reg <= '0;
    end else if (lead_cnt_reg != '1) begin
      lead_cnt_reg <= lead_cnt_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || pwr_init_i);

  sequence s_enter_busy;
    state_reg == rtc_pkg::UPD_PENDING ##1 state_reg == rtc_pkg::UPD_BUSY;
  endsequence

  sequence s_hold_write;
    wr_ctrl && dat_i[rtc_pkg::SET_BIT] ##1 set_reg;
  endsequence

  ctrl_read_zero_a: assert property (ack_reg && $past(rd) && rd_idx_reg == rtc_pkg::IDX_CTRL
    |-> dat_o[0] == 1'b0 && dat_o[3] == 1'b0)
    else $error("control read shows reserved bits set");

  flag_low_zero_a: assert property (ack_reg && $past(rd) && rd_idx_reg == rtc_pkg::IDX_FLAGS
    |-> dat_o[3:0] == 4'h0 && dat_o[31:8] == 24'h0)
    else $error("flag read shows low bits set");

  valid_low_zero_a: assert property (ack_reg && $past(rd) && rd_idx_reg == rtc_pkg::IDX_VALID
    |-> dat_o[6:0] == 7'h00)
    else $error("valid read shows low bits set");

  update_lead_a: assert property (s_enter_busy
    |-> $past(lead_cnt_reg) >= CNT_W'(UIP_LEAD_CYC - 1) && update_pending)
    else $error("update began without pending lead time");

  hold_abort_a: assert property (s_hold_write |=> state_reg == rtc_pkg::UPD_IDLE
    && !update_pending ##1 !time_advance_o)
    else $error("update hold did not stop the update");

  done_enable_clr_a: assert property (wr_ctrl && dat_i[rtc_pkg::SET_BIT] && !set_reg
    |=> !update_done_irq_enable_reg && set_reg)
    else $error("update done enable survived hold rising");

  periodic_flag_a: assert property (periodic_p && !periodic_irq_enable_reg
    |=> flags_reg[2] ##0 (irq_out_n_o || alarm_irq_enable_reg || update_done_irq_enable_reg))
    else $error("periodic flag missing or gated wrongly");

  flag_read_clr_a: assert property (rd_flags && flags_reg[0] && !upd_done
    |=> !flags_reg[0] ##0 $past(rd_mux[4]))
    else $error("update done flag not cleared by read");

  irq_pin_a: assert property (flags_reg[1] && alarm_irq_enable_reg
    |-> !irq_out_n_o && irq_summary_flag)
    else $error("alarm flag with enable left pin high");

  done_flag_a: assert property (upd_done |=> flags_reg[0] && state_reg == rtc_pkg::UPD_IDLE)
    else $error("update end did not set its flag");

  valid_set_a: assert property (rd && idx == rtc_pkg::IDX_VALID && !battery_low_i
    |=> time_valid_flag_reg)
    else $error("valid bit not set by its read");

  rate_hold_a: assert property (disable iff (pwr_init_i) rst_i |=> $stable(periodic_rate_code_reg)
    && $stable(divider_mode_bits_reg) && $stable(set_reg))
    else $error("host reset changed divider controls");
endmodule // rtc_control_status_regs

/* File: dv/wb_host_model.sv */
`timescale 1ns/100ps
// ***********************************************************
// host software model: classic wishbone single cycles
// ***********************************************************
module wb_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // one cycle: hold everything until ack is sampled, then release with scrambled lines
  task automatic bus_cycle(input logic w, input logic [9:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    adr_o <= ~a;
    sel_o <= 4'h0;
    dat_o <= ~d;
  endtask
endmodule // wb_host_model

/* File: dv/tb_rtc_control_status_regs.sv */
`timescale 1ns/100ps
// ***********************************************************
// bench for the rtc control and status registers
// ***********************************************************
module tb_rtc_control_status_regs;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pwr_init_i = 1'b1;
  logic battery_low_i = 1'b0;
  logic cyc, stb, we, ack_o, irq_out_n_o, time_advance_o, binary_format_o, hour24_o;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_o;
  logic [31:0] exp_q[$];
  logic [7:0] d;
  int n_errors = 0;
  int checked = 0;
  int cyc_cnt = 0;
  int n_adv = 0;
  int seed = 42228;
  int t0, t1, t2, k, per;
  int codes[7] = '{1, 2, 4, 5, 6, 7, 8};

  always #20 clk_i = ~clk_i;

  // tick every cycle, short update phases
  rtc_control_status_regs #(.UIP_LEAD_CYC(8), .UPD_CYC(16), .OSC_STEP(4), .CLK_MODULUS(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .pwr_init_i(pwr_init_i), .battery_low_i(battery_low_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o),
    .ack_o(ack_o), .irq_out_n_o(irq_out_n_o), .time_advance_o(time_advance_o),
    .binary_format_o(binary_format_o), .hour24_o(hour24_o));

  wb_host_model host (.clk_i(clk_i), .ack_i(ack_o), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(dat_w));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    host.bus_cycle(1'b1, {idx, 2'b00}, 4'h1, {24'h0, v});
  endtask

  // note the expected byte, the monitor compares when the answer comes
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    host.bus_cycle(1'b0, {idx, 2'b00}, 4'hF, 32'h0);
  endtask

  // wait for the interrupt pin to go low, sampled away from the edge
  task automatic wait_irq(output int t);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (irq_out_n_o !== 1'b0 && k < 400);
    t = cyc_cnt;
    @(posedge clk_i);
    check(k < 400, 1);
  endtask

  // wait for the update pulse, returning the cycles spent
  task automatic wait_adv(output int n);
    n = cyc_cnt;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (time_advance_o !== 1'b1 && k < 20000);
    n = cyc_cnt - n;
  endtask

  task automatic reset_pulse();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check(irq_out_n_o, 1);
  endtask

  // monitor: cycle count, update pulses, read answers against oldest note
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (time_advance_o === 1'b1) n_adv++;
    if (ack_o === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) check(dat_o, 32'hFFFFFFFF);
      else check(dat_o, exp_q.pop_front());
    end
  end

  // watchdog
  initial begin
    repeat (70000) @(posedge clk_i);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    pwr_init_i <= 1'b0;
    // status registers, read side effects, ignored writes
    rd(8'h0A, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h0D, 8'h00);
    rd(8'h0D, 8'h80);
    wr(8'h0C, 8'hFF);
    wr(8'h0D, 8'hFF);
    rd(8'h0C, 8'h00);
    rd(8'h0D, 8'h80);
    battery_low_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    battery_low_i <= 1'b0;
    rd(8'h0D, 8'h00);
    // control register: read-only zeros, hold clears update-done enable
    wr(8'h0B, 8'hFF);
    rd(8'h0B, 8'hE6);
    check({binary_format_o, hour24_o}, 2'h3);
    wr(8'h0B, 8'h16);
    rd(8'h0B, 8'h16);
    wr(8'h0B, 8'h96);
    rd(8'h0B, 8'h86);
    // host reset clears enables only
    wr(8'h0B, 8'h74);
    wr(8'h0A, 8'h6F);
    reset_pulse();
    rd(8'h0B, 8'h04);
    rd(8'h0A, 8'h6F);
    check({binary_format_o, hour24_o}, 2'h2);
    // general purpose bytes, a write without the low lane is ignored
    d = 8'($random(seed));
    wr(8'h0E, d);
    host.bus_cycle(1'b1, {8'h0E, 2'b00}, 4'hE, {24'h0, ~d});
    rd(8'h0E, d);
    d = 8'($random(seed));
    wr(8'hFF, d);
    rd(8'hFF, d);
    // every divider mode with the periodic enable off
    for (int dv = 0; dv < 8; dv++) begin
      wr(8'h0A, {1'b0, dv[2:0], 4'h6});
      repeat (80) @(posedge clk_i);
      check(irq_out_n_o, 1);
      wr(8'h0A, 8'h60);
      rd(8'h0C, (dv >= 2 && dv <= 5) ? 8'h40 : 8'h00);
    end
    // periodic rates measured between interrupt falls
    wr(8'h0B, 8'h40);
    foreach (codes[i]) begin
      per = (codes[i] == 1) ? 128 : (codes[i] == 2) ? 256 : (1 << (codes[i] - 1));
      wr(8'h0A, {4'h2, codes[i][3:0]});
      wait_irq(t0);
      rd(8'h0C, 8'hC0);
      wait_irq(t1);
      rd(8'h0C, 8'hC0);
      wait_irq(t2);
      check(t2 - t1, per);
    end
    wr(8'h0A, 8'h60);
    reset_pulse();
    rd(8'h0C, 8'h00);
    // load time under hold, then release the divider and time the first update
    wr(8'h0B, 8'h80);
    wr(8'h00, 8'h17);
    wr(8'h01, 8'h17);
    wr(8'h05, 8'hC3);
    wr(8'h0B, 8'h30);
    wr(8'h0A, 8'h20);
    wait_adv(t0);
    check(t0 >= 16384 && t0 <= 16400, 1);
    wait_irq(t1);
    rd(8'h0C, 8'hB0);
    rd(8'h0C, 8'h00);
    check(irq_out_n_o, 1);
    // seconds alarm one off: the next update ends without the alarm flag
    wr(8'h01, 8'h18);
    wr(8'h0A, 8'h60);
    wr(8'h0A, 8'h20);
    wait_adv(t0);
    check(t0 >= 16384 && t0 <= 16400, 1);
    wait_irq(t1);
    rd(8'h0C, 8'h90);
    // hold blocks updates across the first half second after a release
    wr(8'h0B, 8'hB0);
    rd(8'h0B, 8'hA0);
    t0 = n_adv;
    wr(8'h0A, 8'h60);
    wr(8'h0A, 8'h20);
    repeat (16500) @(posedge clk_i);
    check(n_adv - t0, 0);
    rd(8'h0A, 8'h20);
    summarize();
  end
endmodule // tb_rtc_control_status_regs
